// file: hw/tgid_top.sv
// gradient and id register bank behind the serial register port
`timescale 1ns/100ps
`default_nettype none
`include "tgid_regs.svh"

module tgid_top #(
  parameter int         GRAD_W          = 9,
  // arbitrary value, stands in for the factory-programmed byte
  parameter logic [7:0] SERIAL_ID_BYTE1 = 8'h5A
) (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire tgid_pkg::tgid_req_s reg_req,
  input  wire logic                burst_active,
  input  wire logic                grad_valid,
  input  wire logic [GRAD_W-1:0]   grad_value,
  output var  tgid_pkg::tgid_rsp_s reg_rsp,
  output var  logic                grad_ready
);

  generate
    if (GRAD_W < 9 || GRAD_W > 16) begin : g_bad_width
      $error("tgid_top: GRAD_W must lie in 9..16");
    end
  endgenerate

  // ===========================================================
  // gradient holder
  logic [GRAD_W-1:0] grad_shown;
  // computed only feeds the reset-value check below
  logic              grad_computed;

  tgid_grad_hold #(
    .GRAD_W     (GRAD_W)
  ) u_hold (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .grad_valid (grad_valid),
    .grad_value (grad_value),
    .freeze     (burst_active),
    .shown      (grad_shown),
    .computed   (grad_computed)
  );

  // ===========================================================
  // address decode
  function automatic tgid_pkg::tgid_sel_e tgid_decode(
    input logic [7:0] addr
  );
    tgid_pkg::tgid_sel_e sel;
    case (addr)
      `TGID_ADDR_GRAD_HIGH: sel = tgid_pkg::TGID_SEL_HIGH;
      `TGID_ADDR_GRAD_LOW:  sel = tgid_pkg::TGID_SEL_LOW;
      `TGID_ADDR_SERIAL1:   sel = tgid_pkg::TGID_SEL_SER1;
      default:              sel = tgid_pkg::TGID_SEL_NONE;
    endcase
    return sel;
  endfunction : tgid_decode

  // reserved high bits fall out of the shift as zero
  function automatic logic [7:0] tgid_high_byte(
    input logic [GRAD_W-1:0] g
  );
    return 8'(g >> `TGID_GRAD_HIGH_SHIFT);
  endfunction : tgid_high_byte

  function automatic logic [7:0] tgid_low_byte(
    input logic [GRAD_W-1:0] g
  );
    return g[`TGID_GRAD_LOW_MSB:`TGID_GRAD_LOW_LSB];
  endfunction : tgid_low_byte

  // ===========================================================
  // state
  typedef struct packed {
    tgid_pkg::tgid_rsp_s rsp;
  } tgid_top_s;

  tgid_top_s           st_q;
  tgid_top_s           st_d;
  tgid_pkg::tgid_sel_e sel;

  assign sel = tgid_decode(reg_req.addr);

  always_comb begin
    st_d           = st_q;
    st_d.rsp.ack   = reg_req.rd || reg_req.wr;
    st_d.rsp.hit   = (reg_req.rd || reg_req.wr) &&
                     (sel != tgid_pkg::TGID_SEL_NONE);
    st_d.rsp.rdata = `TGID_RDATA_NONE;
    // writes only earn ack and, if mapped, hit; every register here is read-only
    // rd with wr together: the read supplies the data
    if (reg_req.rd) begin
      case (sel)
        tgid_pkg::TGID_SEL_HIGH: begin
          st_d.rsp.rdata = tgid_high_byte(grad_shown);
        end
        tgid_pkg::TGID_SEL_LOW: begin
          st_d.rsp.rdata = tgid_low_byte(grad_shown);
        end
        tgid_pkg::TGID_SEL_SER1: begin
          st_d.rsp.rdata = SERIAL_ID_BYTE1;
        end
        default: begin
          st_d.rsp.rdata = `TGID_RDATA_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rsp    = st_q.rsp;
  // the holder always takes a result; mid-burst it defers, keeping only the latest
  assign grad_ready = 1'b1;

  // ===========================================================
  // checks
  logic rd_high;
  logic rd_low;
  logic rd_ser1;
  logic rd_none;

  assign rd_high = reg_req.rd && sel == tgid_pkg::TGID_SEL_HIGH;
  assign rd_low  = reg_req.rd && sel == tgid_pkg::TGID_SEL_LOW;
  assign rd_ser1 = reg_req.rd && sel == tgid_pkg::TGID_SEL_SER1;
  assign rd_none = reg_req.rd && sel == tgid_pkg::TGID_SEL_NONE;

  property p_low_byte;
    @(posedge clk_sys) disable iff (!reset_n)
      rd_low |=> reg_rsp.ack && reg_rsp.hit &&
                 reg_rsp.rdata == $past(grad_shown[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low gradient byte read wrong");

  // reserved bits above the sign bit read as zero
  property p_high_byte;
    @(posedge clk_sys) disable iff (!reset_n)
      rd_high |=> reg_rsp.ack &&
                  reg_rsp.rdata[0] == $past(grad_shown[8]) &&
                  reg_rsp.rdata[7:GRAD_W-8] == '0;
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("high gradient byte read wrong");

  // a deferred result may land on the edge after a burst, not a write
  property p_write_no_effect;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_req.wr && !reg_req.rd && !grad_valid && !burst_active &&
        !$past(burst_active)
        |=> $stable(grad_shown) && reg_rsp.ack && reg_rsp.rdata == 8'h00;
  endproperty
  a_write_no_effect: assert property (p_write_no_effect)
    else $error("host write disturbed a read-only register");

  property p_serial_byte;
    @(posedge clk_sys) disable iff (!reset_n)
      rd_ser1 |=> reg_rsp.ack && reg_rsp.hit &&
                  reg_rsp.rdata == SERIAL_ID_BYTE1;
  endproperty
  a_serial_byte: assert property (p_serial_byte)
    else $error("id byte one read wrong");

  sequence s_burst_pair;
    burst_active && rd_high ##1 burst_active && rd_low;
  endsequence

  property p_burst_coherent;
    @(posedge clk_sys) disable iff (!reset_n)
      s_burst_pair |=> reg_rsp.rdata == $past(grad_shown[7:0], 2);
  endproperty
  a_burst_coherent: assert property (p_burst_coherent)
    else $error("burst read mixed two gradient results");

  // unmapped reads still answer, so the host never waits
  property p_unmapped;
    @(posedge clk_sys) disable iff (!reset_n)
      rd_none |=> reg_rsp.ack && !reg_rsp.hit && reg_rsp.rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not answered with zero");

  // the answer stands for exactly one cycle
  property p_ack_once;
    @(posedge clk_sys) disable iff (!reset_n)
      !(reg_req.rd || reg_req.wr) |=> !reg_rsp.ack && !reg_rsp.hit;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("answer raised without a request");

  // reads before the first result must see the reset value
  property p_zero_before_result;
    @(posedge clk_sys) disable iff (!reset_n)
      (rd_high || rd_low) && !grad_computed |=>
        reg_rsp.rdata == 8'(`TGID_GRAD_RESET);
  endproperty
  a_zero_before_result: assert property (p_zero_before_result)
    else $error("gradient byte nonzero before any result");

  // a result taken outside a burst is what the next read returns
  sequence s_fresh_result;
    grad_valid && !burst_active ##1 !grad_valid;
  endsequence

  sequence s_fresh_high_read;
    s_fresh_result ##1 rd_high;
  endsequence

  property p_fresh_high;
    @(posedge clk_sys) disable iff (!reset_n)
      s_fresh_high_read |=> reg_rsp.rdata[0] == $past(grad_value[8], 3);
  endproperty
  a_fresh_high: assert property (p_fresh_high)
    else $error("new gradient result missing from high byte read");

endmodule : tgid_top
`default_nettype wire

// file: hw/tgid_regs.svh
// offsets, field positions and reset values of the gradient and id registers
// What this block does
// - low gradient byte holds bits 7:0
// - high byte bit 0 holds bit 8
// - gradient registers read-only, reset to zero
// - id byte one is fixed, read-only
`ifndef TGID_REGS_SVH
`define TGID_REGS_SVH

// ===========================================================
// register offsets
`define TGID_ADDR_GRAD_HIGH   8'h2D
`define TGID_ADDR_GRAD_LOW    8'h2E
`define TGID_ADDR_SERIAL1     8'h30

// ===========================================================
// field positions
`define TGID_GRAD_LOW_MSB     7
`define TGID_GRAD_LOW_LSB     0
`define TGID_GRAD_HIGH_SHIFT  8

// ===========================================================
// reset and fill values
`define TGID_GRAD_RESET       16'h0000
`define TGID_RDATA_NONE       8'h00

`endif

// file: hw/tgid_pkg.sv
// types shared by the gradient and id register bank
`default_nettype none
package tgid_pkg;

  // one register access from the serial interface logic
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tgid_req_s;

  // answer, one cycle after a read or write
  typedef struct packed {
    logic       ack;
    logic       hit;
    logic [7:0] rdata;
  } tgid_rsp_s;

  // which register an address selects
  typedef enum logic [3:0] {
    TGID_SEL_NONE = 4'b0001,
    TGID_SEL_HIGH = 4'b0010,
    TGID_SEL_LOW  = 4'b0100,
    TGID_SEL_SER1 = 4'b1000
  } tgid_sel_e;

endpackage : tgid_pkg
`default_nettype wire

// file: hw/tgid_grad_hold.sv
// holds the latest gradient and the copy the host sees
`timescale 1ns/100ps
`default_nettype none
`include "tgid_regs.svh"

module tgid_grad_hold #(
  parameter int GRAD_W = 9
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              grad_valid,
  input  wire logic [GRAD_W-1:0] grad_value,
  input  wire logic              freeze,
  output logic      [GRAD_W-1:0] shown,
  output logic                   computed
);

  generate
    if (GRAD_W < 9 || GRAD_W > 16) begin : g_bad_width
      $error("tgid_grad_hold: GRAD_W must lie in 9..16");
    end
  endgenerate

  typedef struct packed {
    logic [GRAD_W-1:0] live;
    logic [GRAD_W-1:0] shown;
    logic              pending;
    logic              computed;
  } tgid_hold_s;

  tgid_hold_s st_q;
  tgid_hold_s st_d;

  // ===========================================================
  // next state
  always_comb begin
    st_d = st_q;
    if (grad_valid) begin
      st_d.live     = grad_value;
      st_d.computed = 1'b1;
      if (!freeze) begin
        st_d.shown   = grad_value;
        st_d.pending = 1'b0;
      end else begin
        // a new result mid-burst would tear the two bytes
        st_d.pending = 1'b1;
      end
    end else if (!freeze && st_q.pending) begin
      st_d.shown   = st_q.live;
      st_d.pending = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign shown    = st_q.shown;
  assign computed = st_q.computed;

  // ===========================================================
  // checks
  sequence s_frozen;
    freeze && $past(freeze);
  endsequence

  sequence s_release_pending;
    !freeze && st_q.pending && !grad_valid;
  endsequence

  property p_zero_until_computed;
    @(posedge clk_sys) disable iff (!reset_n)
      !computed |-> shown == GRAD_W'(`TGID_GRAD_RESET);
  endproperty
  a_zero_until_computed: assert property (p_zero_until_computed)
    else $error("gradient nonzero before any result");

  property p_frozen_stable;
    @(posedge clk_sys) disable iff (!reset_n)
      s_frozen |-> $stable(shown);
  endproperty
  a_frozen_stable: assert property (p_frozen_stable)
    else $error("shown gradient changed during a burst");

  property p_pending_applied;
    @(posedge clk_sys) disable iff (!reset_n)
      s_release_pending |=> shown == $past(st_q.live) && !st_q.pending;
  endproperty
  a_pending_applied: assert property (p_pending_applied)
    else $error("held result not applied after burst");

endmodule : tgid_grad_hold
`default_nettype wire

// file: sim/tgid_host_model.sv
// host-side model of the serial register port
`timescale 1ns/100ps
`default_nettype none
`include "tgid_regs.svh"

module tgid_host_model (
  input  wire logic                clk_sys,
  input  wire tgid_pkg::tgid_rsp_s reg_rsp,
  output var  tgid_pkg::tgid_req_s reg_req,
  output var  logic                burst_active
);
  initial begin
    reg_req      = '0;
    burst_active = 1'b0;
  end

  // ===========================================================
  // single access: answer is taken two edges after the request is driven
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      output tgid_pkg::tgid_rsp_s rsp);
    @(posedge clk_sys);
    reg_req <= '{rd: !wr, wr: wr, addr: addr, wdata: 8'hFF};
    @(posedge clk_sys);
    reg_req <= '0;
    @(posedge clk_sys);
    rsp = reg_rsp;
  endtask : xfer

  // ===========================================================
  // both gradient bytes in one burst, back to back
  task automatic burst(output tgid_pkg::tgid_rsp_s hi,
                       output tgid_pkg::tgid_rsp_s lo);
    @(posedge clk_sys);
    burst_active <= 1'b1;
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: `TGID_ADDR_GRAD_HIGH, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req.addr <= `TGID_ADDR_GRAD_LOW;
    @(posedge clk_sys);
    reg_req <= '0;
    hi = reg_rsp;
    @(posedge clk_sys);
    lo = reg_rsp;
    burst_active <= 1'b0;
  endtask : burst
endmodule : tgid_host_model
`default_nettype wire

// file: sim/thermal_gradient_id_regs_bench.sv
// self-checking bench for the gradient and id register bank
`timescale 1ns/100ps
`default_nettype none
`include "tgid_regs.svh"

module thermal_gradient_id_regs_bench;
  // arbitrary value, stands in for the factory byte
  localparam logic [7:0] SER = 8'hC3;
  logic                clk_sys;
  logic                reset_n;
  logic                grad_valid;
  logic [8:0]          grad_value;
  logic                grad_ready;
  tgid_pkg::tgid_req_s reg_req;
  tgid_pkg::tgid_rsp_s reg_rsp;
  logic                burst_active;
  tgid_pkg::tgid_rsp_s r;
  tgid_pkg::tgid_rsp_s r2;
  int                  failures = 0;
  int                  n_tests = 0;
  int                  cycles = 0;
  logic [8:0]          vals [4] = '{9'h1F3, 9'h0FF, 9'h100, 9'h001};
  logic [7:0]          wadr [3] = '{8'h2D, 8'h2E, 8'h30};

  tgid_top #(.GRAD_W(9), .SERIAL_ID_BYTE1(SER)) tgid_top_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
    .burst_active(burst_active), .grad_valid(grad_valid),
    .grad_value(grad_value), .reg_rsp(reg_rsp), .grad_ready(grad_ready)
  );

  tgid_host_model tgid_host_model_inst (
    .clk_sys(clk_sys), .reg_rsp(reg_rsp), .reg_req(reg_req),
    .burst_active(burst_active)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ===========================================================
  // checking
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input tgid_pkg::tgid_rsp_s got, input logic h,
                     input logic [7:0] d);
    n_tests++;
    if ({got.ack, got.hit, got.rdata} !== {1'b1, h, d}) begin
      failures++;
      $display("[FAIL] %0t answer %b/%b/%h, wanted %b/%h", $time,
               got.ack, got.hit, got.rdata, h, d);
    end
  endtask : chk

  task automatic chk_flag(input logic got, input logic want);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] %0t flag %b, wanted %b", $time, got, want);
    end
  endtask : chk_flag

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] d,
                        input logic h);
    tgid_pkg::tgid_rsp_s q;
    tgid_host_model_inst.xfer(1'b0, a, q);
    chk(q, h, d);
  endtask : rd_chk

  task automatic load(input logic [8:0] v);
    @(posedge clk_sys);
    grad_valid <= 1'b1;
    grad_value <= v;
    @(posedge clk_sys);
    grad_valid <= 1'b0;
  endtask : load

  // hang guard, well above the roughly 92 cycles of the sequence
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  // ===========================================================
  // sequence
  initial begin
    reset_n    = 1'b0;
    grad_valid = 1'b0;
    grad_value = 9'h000;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(`TGID_ADDR_GRAD_HIGH, 8'h00, 1'b1);
    rd_chk(`TGID_ADDR_GRAD_LOW, 8'h00, 1'b1);
    rd_chk(`TGID_ADDR_SERIAL1, SER, 1'b1);
    rd_chk(8'h2F, 8'h00, 1'b0);
    rd_chk(8'h2C, 8'h00, 1'b0);
    foreach (vals[i]) begin
      load(vals[i]);
      rd_chk(`TGID_ADDR_GRAD_HIGH, {7'h00, vals[i][8]}, 1'b1);
      rd_chk(`TGID_ADDR_GRAD_LOW, vals[i][7:0], 1'b1);
    end
    // writes are answered but leave every register as it was
    foreach (wadr[i]) begin
      tgid_host_model_inst.xfer(1'b1, wadr[i], r);
      chk(r, 1'b1, 8'h00);
    end
    rd_chk(`TGID_ADDR_GRAD_HIGH, 8'h00, 1'b1);
    rd_chk(`TGID_ADDR_GRAD_LOW, 8'h01, 1'b1);
    rd_chk(`TGID_ADDR_SERIAL1, SER, 1'b1);
    // new result lands mid-burst; both bytes must stay with the old one
    fork
      tgid_host_model_inst.burst(r, r2);
      begin
        repeat (2) @(posedge clk_sys);
        grad_valid <= 1'b1;
        grad_value <= 9'h155;
        chk_flag(grad_ready, 1'b1);
        @(posedge clk_sys);
        grad_valid <= 1'b0;
      end
    join
    chk(r, 1'b1, 8'h00);
    chk(r2, 1'b1, 8'h01);
    rd_chk(`TGID_ADDR_GRAD_HIGH, 8'h01, 1'b1);
    rd_chk(`TGID_ADDR_GRAD_LOW, 8'h55, 1'b1);
    // a second reset must take the gradient back to zero
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(`TGID_ADDR_GRAD_HIGH, 8'h00, 1'b1);
    rd_chk(`TGID_ADDR_GRAD_LOW, 8'h00, 1'b1);
    conclude();
  end
endmodule : thermal_gradient_id_regs_bench
`default_nettype wire
